// ===== src/axil_slave_port.v
`timescale 1ns/10ps
`include "core_subset_regs.vh"
module axil_slave_port (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg wr_en,
   output reg [7:0] wr_addr,
   output reg [31:0] wr_data,
   output reg [3:0] wr_strb,
   input wire wr_ok,
   output wire [7:0] rd_addr,
   input wire [31:0] rd_data,
   input wire rd_ok
);
   reg aw_have_q;
   reg w_have_q;

   assign rd_addr = s_axi_araddr;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else begin
         wr_en <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // The write takes effect one cycle after bvalid rises.
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            wr_en <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // axil_slave_port

// ===== src/core_subset_regs.vh
`ifndef CORE_SUBSET_REGS_VH
`define CORE_SUBSET_REGS_VH

// Register byte offsets on the AXI4-Lite port.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ACC_X 8'h08
`define REG_PC 8'h0c

// Field positions.
`define CTRL_RUN 0
`define CTRL_RESUME 1
`define STAT_WAIT 0
`define STAT_BAD 1
`define STAT_RUN 2
`define FLAG_H 4
`define FLAG_I 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0

// Reset values and the trap vector.
`define RST_PC 16'h0000
`define RST_STACK 8'hff
`define RST_FLAGS 5'h08
`define TRAP_VECTOR 16'hfffc

// Opcodes and opcode fields.
`define OP_TRAP 8'h83
`define OP_TO_X 8'h97
`define OP_TO_A 8'h9f
`define OP_HALT 8'h8f
`define LO_SUB 4'h0
`define LO_MTEST 4'hd

// Cycle counts per instruction form.
`define CYC_SUB_LIT 4'd2
`define CYC_SUB_ZP 4'd3
`define CYC_SUB_LONG 4'd4
`define CYC_SUB_W_OFS 4'd5
`define CYC_SUB_B_OFS 4'd4
`define CYC_SUB_N_OFS 4'd3
`define CYC_MT_ZP 4'd4
`define CYC_MT_REG 4'd3
`define CYC_MT_B_OFS 4'd5
`define CYC_MT_N_OFS 4'd4
`define CYC_TRAP 4'd10
`define CYC_COPY 4'd2
`define CYC_HALT 4'd2
`define CYC_BAD 4'd2

// Instruction kinds.
`define K_SUB 4'h0
`define K_TSTM 4'h1
`define K_TSTA 4'h2
`define K_TSTX 4'h3
`define K_TO_X 4'h4
`define K_TO_A 4'h5
`define K_HALT 4'h6
`define K_TRAP 4'h7
`define K_BAD 4'h8

// Operand address forms.
`define EA_NONE 2'd0
`define EA_ABS 2'd1
`define EA_IDX 2'd2
`define EA_X 2'd3

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== src/cpu_subset_core.v
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "core_subset_regs.vh"
module cpu_subset_core #(
   parameter [15:0] RESET_PC = `RST_PC,
   parameter [15:0] VECTOR_ADDR = `TRAP_VECTOR
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   output reg [15:0] mem_addr,
   output reg mem_rd,
   output reg mem_wr,
   output reg [7:0] mem_wdata,
   input wire [7:0] mem_rdata,
   output wire cpu_waiting
);
   localparam [2:0] ST_HALT = 3'b001;
   localparam [2:0] ST_EXEC = 3'b010;
   localparam [2:0] ST_WAIT = 3'b100;

   // Packs {address form, kind, operand bytes, index of last cycle}.
   function [11:0] decode;
      input [7:0] op;
      begin
         case (op)
            8'ha0: decode = {`EA_NONE, `K_SUB, 2'd1, `CYC_SUB_LIT - 4'd1};
            8'hb0: decode = {`EA_ABS, `K_SUB, 2'd1, `CYC_SUB_ZP - 4'd1};
            8'hc0: decode = {`EA_ABS, `K_SUB, 2'd2, `CYC_SUB_LONG - 4'd1};
            8'hd0: decode = {`EA_IDX, `K_SUB, 2'd2, `CYC_SUB_W_OFS - 4'd1};
            8'he0: decode = {`EA_IDX, `K_SUB, 2'd1, `CYC_SUB_B_OFS - 4'd1};
            8'hf0: decode = {`EA_X, `K_SUB, 2'd0, `CYC_SUB_N_OFS - 4'd1};
            8'h3d: decode = {`EA_ABS, `K_TSTM, 2'd1, `CYC_MT_ZP - 4'd1};
            8'h4d: decode = {`EA_NONE, `K_TSTA, 2'd0, `CYC_MT_REG - 4'd1};
            8'h5d: decode = {`EA_NONE, `K_TSTX, 2'd0, `CYC_MT_REG - 4'd1};
            8'h6d: decode = {`EA_IDX, `K_TSTM, 2'd1, `CYC_MT_B_OFS - 4'd1};
            8'h7d: decode = {`EA_X, `K_TSTM, 2'd0, `CYC_MT_N_OFS - 4'd1};
            `OP_TRAP: decode = {`EA_NONE, `K_TRAP, 2'd0, `CYC_TRAP - 4'd1};
            `OP_TO_X: decode = {`EA_NONE, `K_TO_X, 2'd0, `CYC_COPY - 4'd1};
            `OP_TO_A: decode = {`EA_NONE, `K_TO_A, 2'd0, `CYC_COPY - 4'd1};
            `OP_HALT: decode = {`EA_NONE, `K_HALT, 2'd0, `CYC_HALT - 4'd1};
            default: decode = {`EA_NONE, `K_BAD, 2'd0, `CYC_BAD - 4'd1};
         endcase
      end
   endfunction

   reg [2:0] state_q;
   reg [3:0] step_q;
   reg [7:0] op_q;
   reg [7:0] hi_q;
   reg [7:0] lo_q;
   reg [7:0] a_q;
   reg [7:0] x_q;
   reg [7:0] stk_q;
   reg [15:0] pc_q;
   reg h_q;
   reg i_q;
   reg n_q;
   reg z_q;
   reg c_q;
   reg run_q;
   reg bad_q;
   reg resume_q;
   reg [31:0] rd_data;
   reg rd_ok;
   reg [15:0] ea;
   reg [7:0] push_byte;
   wire wr_en;
   wire [7:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire wr_ok;
   wire [7:0] rd_addr;
   wire [7:0] op;
   wire [11:0] dc;
   wire [3:0] last;
   wire [1:0] nb;
   wire [3:0] kind;
   wire [1:0] ea_mode;
   wire at_end;
   wire live;
   wire grab;
   wire [15:0] next_pc;
   wire [15:0] two;
   wire [7:0] one;
   wire [15:0] base;
   wire [7:0] alu_a;
   wire [7:0] alu_b;
   wire [7:0] diff;
   wire neg;
   wire zero;
   wire borrow;
   wire [7:0] flags_byte;
   wire bad_set;

   axil_slave_port bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // In the first cycle of an instruction the opcode is still on the bus.
   assign op = (step_q == 4'd0) ? mem_rdata : op_q;
   assign dc = decode(op);
   assign last = dc[3:0];
   assign nb = dc[5:4];
   assign kind = dc[9:6];
   assign ea_mode = dc[11:10];
   assign at_end = (step_q == last);
   assign live = (step_q == {2'b00, nb});
   assign grab = (step_q != 4'd0) && (step_q <= {2'b00, nb});
   assign next_pc = (step_q <= {2'b00, nb}) ? pc_q + 16'h0001 : pc_q;
   assign two = live ? {lo_q, mem_rdata} : {hi_q, lo_q};
   assign one = live ? mem_rdata : lo_q;
   assign base = (nb == 2'd2) ? two : {8'h00, one};

   always @* begin
      case (ea_mode)
         `EA_IDX: ea = base + {8'h00, x_q};
         `EA_X: ea = {8'h00, x_q};
         default: ea = base;
      endcase
   end

   assign alu_a = (kind == `K_SUB || kind == `K_TSTA) ? a_q :
                  (kind == `K_TSTX) ? x_q : mem_rdata;
   assign alu_b = (kind == `K_SUB) ? mem_rdata : 8'h00;

   sub_flag_unit alu (
      .minuend(alu_a),
      .subtrahend(alu_b),
      .diff(diff),
      .neg(neg),
      .zero(zero),
      .borrow(borrow)
   );

   assign flags_byte = {3'b111, h_q, i_q, n_q, z_q, c_q};

   always @* begin
      case (step_q)
         4'd1: push_byte = pc_q[7:0];
         4'd2: push_byte = pc_q[15:8];
         4'd3: push_byte = x_q;
         4'd4: push_byte = a_q;
         default: push_byte = flags_byte;
      endcase
   end

   assign cpu_waiting = state_q[2];

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_HALT;
         step_q <= 4'd0;
         op_q <= 8'h00;
         hi_q <= 8'h00;
         lo_q <= 8'h00;
         a_q <= 8'h00;
         x_q <= 8'h00;
         stk_q <= `RST_STACK;
         pc_q <= RESET_PC;
         {h_q, i_q, n_q, z_q, c_q} <= `RST_FLAGS;
         mem_addr <= 16'h0000;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_wdata <= 8'h00;
      end else begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         case (state_q)
            ST_HALT: begin
               if (run_q) begin
                  mem_addr <= pc_q;
                  mem_rd <= 1'b1;
                  step_q <= 4'd0;
                  state_q <= ST_EXEC;
               end
            end
            ST_WAIT: begin
               // Wake-up restarts at the byte after the halt opcode.
               if (resume_q) begin
                  mem_addr <= pc_q;
                  mem_rd <= run_q;
                  step_q <= 4'd0;
                  state_q <= run_q ? ST_EXEC : ST_HALT;
               end
            end
            ST_EXEC: begin
               if (step_q == 4'd0)
                  op_q <= mem_rdata;
               if (grab) begin
                  hi_q <= lo_q;
                  lo_q <= mem_rdata;
               end
               pc_q <= next_pc;
               step_q <= step_q + 4'd1;
               if (at_end) begin
                  step_q <= 4'd0;
                  case (kind)
                     `K_SUB: begin
                        a_q <= diff;
                        n_q <= neg;
                        z_q <= zero;
                        c_q <= borrow;
                     end
                     `K_TSTM, `K_TSTA, `K_TSTX: begin
                        n_q <= neg;
                        z_q <= zero;
                     end
                     `K_TO_X: x_q <= a_q;
                     `K_TO_A: a_q <= x_q;
                     `K_HALT: i_q <= 1'b0;
                     `K_TRAP: pc_q <= {lo_q, mem_rdata};
                     default: pc_q <= next_pc;
                  endcase
                  if (kind == `K_HALT) begin
                     state_q <= ST_WAIT;
                  end else if (run_q) begin
                     mem_addr <= (kind == `K_TRAP) ? {lo_q, mem_rdata}
                                                  : next_pc;
                     mem_rd <= 1'b1;
                  end else begin
                     state_q <= ST_HALT;
                  end
               end else if (step_q < {2'b00, nb}) begin
                  mem_addr <= next_pc;
                  mem_rd <= 1'b1;
               end else if (ea_mode != `EA_NONE &&
                            step_q == last - 4'd1) begin
                  mem_addr <= ea;
                  mem_rd <= 1'b1;
               end else if (kind == `K_TRAP) begin
                  if (step_q >= 4'd1 && step_q <= 4'd5) begin
                     mem_addr <= {8'h00, stk_q};
                     mem_wdata <= push_byte;
                     mem_wr <= 1'b1;
                     stk_q <= stk_q - 8'h01;
                  end else if (step_q == 4'd6) begin
                     i_q <= 1'b1;
                  end else if (step_q == 4'd7) begin
                     mem_addr <= VECTOR_ADDR;
                     mem_rd <= 1'b1;
                  end else if (step_q == 4'd8) begin
                     lo_q <= mem_rdata;
                     mem_addr <= VECTOR_ADDR + 16'h0001;
                     mem_rd <= 1'b1;
                  end
               end
            end
            default: state_q <= ST_HALT;
         endcase
      end
   end

   assign bad_set = state_q[1] && at_end && (kind == `K_BAD);
   assign wr_ok = (wr_addr == `REG_CTRL) || (wr_addr == `REG_STATUS) ||
                  (wr_addr == `REG_ACC_X) || (wr_addr == `REG_PC);

   // A fresh unknown opcode wins over a clear in the same cycle.
   always @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= 1'b0;
         bad_q <= 1'b0;
         resume_q <= 1'b0;
      end else begin
         resume_q <= 1'b0;
         if (wr_en && wr_addr == `REG_CTRL && wr_strb[0]) begin
            run_q <= wr_data[`CTRL_RUN];
            resume_q <= wr_data[`CTRL_RESUME];
         end
         if (bad_set)
            bad_q <= 1'b1;
         else if (wr_en && wr_addr == `REG_STATUS && wr_strb[0] &&
                  wr_data[`STAT_BAD])
            bad_q <= 1'b0;
      end
   end

   always @* begin
      rd_ok = 1'b1;
      case (rd_addr)
         `REG_CTRL: rd_data = {31'h0, run_q};
         `REG_STATUS: rd_data = {29'h0, state_q[1], bad_q, state_q[2]};
         `REG_ACC_X: rd_data = {3'h0, h_q, i_q, n_q, z_q, c_q,
                                stk_q, x_q, a_q};
         `REG_PC: rd_data = {16'h0, pc_q};
         default: begin
            rd_data = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end
endmodule // cpu_subset_core

// ===== src/sub_flag_unit.v
`timescale 1ns/10ps
module sub_flag_unit (
   input wire [7:0] minuend,
   input wire [7:0] subtrahend,
   output wire [7:0] diff,
   output wire neg,
   output wire zero,
   output wire borrow
);
   wire [8:0] full;

   assign full = {1'b0, minuend} - {1'b0, subtrahend};
   assign diff = full[7:0];
   assign neg = full[7];
   assign zero = (full[7:0] == 8'h00);
   assign borrow = full[8];
endmodule // sub_flag_unit

// ===== test/cpu_subset_chk.sv
`timescale 1ns/10ps
module cpu_subset_chk #(
   parameter [15:0] VECTOR_ADDR = 16'hfffc
) (
   input wire aclk,
   input wire aresetn,
   input wire [15:0] mem_addr,
   input wire mem_rd,
   input wire mem_wr,
   input wire [7:0] mem_wdata,
   input wire [7:0] mem_rdata,
   input wire cpu_waiting
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_STACK_PAGE: assert property (
      mem_wr |-> mem_addr[15:8] == 8'h00)
      else $error("write outside page zero");
   AST_PUSH_DOWN: assert property (
      mem_wr ##1 mem_wr |-> mem_addr == $past(mem_addr) - 16'h0001)
      else $error("push address did not step down");
   AST_PUSH_FIVE: assert property (
      $rose(mem_wr) |-> mem_wr [*5] ##1 !mem_wr)
      else $error("trap did not push five bytes");
   AST_FLAGS_BYTE: assert property (
      $fell(mem_wr) |-> ($past(mem_wdata) & 8'he0) == 8'he0)
      else $error("pushed flag byte lacks top ones");
   AST_VECTOR_READ: assert property (
      $fell(mem_wr) |-> !mem_rd ##1 (mem_rd && mem_addr == VECTOR_ADDR)
         ##1 (mem_rd && mem_addr == VECTOR_ADDR + 16'h0001))
      else $error("vector not read high then low");
   AST_HALT_ENTRY: assert property (
      $rose(cpu_waiting) |-> $past(mem_rd, 2) && !$past(mem_rd)
         && $past(mem_rdata, 2) == 8'h8f)
      else $error("waiting rose without a halt fetch");
   AST_HALT_QUIET: assert property (
      $rose(cpu_waiting) |-> (!mem_rd && !mem_wr) [*4])
      else $error("memory active while halted");
   AST_COPY_TO_X: assert property (
      mem_rd && mem_rdata == 8'h97 |=> (!mem_rd && !mem_wr)
         ##1 (mem_rd && mem_addr == $past(mem_addr, 2) + 16'h0001))
      else $error("copy to index not two cycles");
   AST_COPY_TO_A: assert property (
      mem_rd && mem_rdata == 8'h9f |=> (!mem_rd && !mem_wr)
         ##1 (mem_rd && mem_addr == $past(mem_addr, 2) + 16'h0001))
      else $error("copy to accumulator not two cycles");
   AST_NO_OFFSET: assert property (
      mem_rd && mem_rdata == 8'hf0 |=> !mem_rd
         ##1 (mem_rd && mem_addr[15:8] == 8'h00)
         ##1 (mem_rd && mem_addr == $past(mem_addr, 3) + 16'h0001))
      else $error("no-offset subtract sequence wrong");
endmodule // cpu_subset_chk

bind cpu_subset_core cpu_subset_chk #(.VECTOR_ADDR(VECTOR_ADDR)) chk (
   .aclk(aclk), .aresetn(aresetn), .mem_addr(mem_addr), .mem_rd(mem_rd),
   .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
   .cpu_waiting(cpu_waiting));

// ===== test/prog_mem_model.sv
`timescale 1ns/10ps
module prog_mem_model (
   input wire logic aclk,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] ram [0:65535];
   logic [7:0] last_q = 8'h5a;

   // Between reads the bus shows the inverse of the last byte, so a core
   // sampling outside its read cycle sees a wrong value, not a lucky one.
   assign mem_rdata = mem_rd ? ram[mem_addr] : ~last_q;
   always @(posedge aclk) begin
      if (mem_wr === 1'b1) begin
         ram[mem_addr] <= mem_wdata;
      end
      if (mem_rd === 1'b1) begin
         last_q <= ram[mem_addr];
      end
   end
endmodule // prog_mem_model

// ===== test/testbench.sv
`timescale 1ns/10ps
module testbench;
   localparam logic [15:0] VEC = 16'hfffc;
   logic aclk, mem_rd, mem_wr, cpu_waiting;
   logic aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   logic [15:0] pc_m = 16'h0000;
   logic [7:0] a_m = 8'h00, x_m = 8'h00, stk_m = 8'hff;
   logic n_m = 1'b0, z_m = 1'b0, c_m = 1'b0;
   logic [15:0] la[$];
   int lt[$];
   int cyc, fails, n_compared;

   cpu_subset_core #(.RESET_PC(16'h0000), .VECTOR_ADDR(VEC)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .cpu_waiting(cpu_waiting));

   prog_mem_model mem (.aclk(aclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Log of every read cycle, sampled mid-cycle where the bus is settled.
   always @(negedge aclk) begin
      cyc++;
      if (mem_rd === 1'b1) begin
         la.push_back(mem_addr);
         lt.push_back(cyc);
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic hang();
      check(32'h0, 32'h1);
      final_report();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
         output logic [1:0] r);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      if (k == 50) hang();
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (k == 50) hang();
   endtask

   // Cycles from the read of a0 to the next read of a1, and the read before.
   task automatic gap(input logic [15:0] a0, input logic [15:0] a1,
         output int dt, output logic [15:0] last);
      int i0;
      i0 = -1;
      dt = -1;
      last = 16'h0;
      for (int k = 0; k < la.size(); k++) begin
         if (i0 < 0 && la[k] === a0) begin
            i0 = k;
         end else if (i0 >= 0 && la[k] === a1) begin
            dt = lt[k] - lt[i0];
            last = la[k - 1];
            break;
         end
      end
   endtask

   task automatic wait_halt();
      int k;
      repeat (3) @(negedge aclk);
      for (k = 0; k < 200 && cpu_waiting !== 1'b1; k++) @(negedge aclk);
      if (k == 200) hang();
   endtask

   task automatic acc_check();
      logic [31:0] d;
      logic [1:0] r;
      axi_read(8'h08, d, r);
      check(d, {5'h0, n_m, z_m, c_m, stk_m, x_m, a_m});
   endtask

   // Runs one instruction followed by a halt, then checks timing and state.
   task automatic exec(input logic [23:0] code, input int nb, input int n,
         input logic [15:0] ea);
      int dt;
      logic [15:0] last;
      logic [1:0] r;
      for (int i = 0; i < nb; i++) mem.ram[pc_m + i] = code[23 - 8 * i -: 8];
      mem.ram[pc_m + nb] = 8'h8f;
      la.delete();
      lt.delete();
      axi_write(8'h00, 32'h3, r);
      wait_halt();
      gap(pc_m, pc_m + nb, dt, last);
      check(32'(dt), 32'(n));
      check(32'(last), 32'(ea));
      pc_m = pc_m + 16'(nb) + 16'h1;
      acc_check();
   endtask

   function automatic void nz(input logic [7:0] v);
      n_m = v[7];
      z_m = (v == 8'h00);
   endfunction

   function automatic void sub(input logic [7:0] m);
      {c_m, a_m} = {1'b0, a_m} - {1'b0, m};
      nz(a_m);
   endfunction

   task automatic test_regs();
      logic [31:0] d;
      logic [1:0] r;
      axi_read(8'h08, d, r);
      check(d, 32'h08ff0000);
      axi_write(8'h08, 32'h12345678, r);
      check(32'(r), 32'h0);
      axi_read(8'h08, d, r);
      check(d, 32'h08ff0000);
      axi_read(8'h10, d, r);
      check({d[29:0], r}, 32'h2);
      axi_write(8'h10, 32'h1, r);
      check(32'(r), 32'h2);
      $display("register test done");
   endtask

   task automatic test_copy();
      sub(8'h05);
      exec(24'ha00500, 2, 2, pc_m + 16'h1);
      x_m = a_m;
      exec(24'h970000, 1, 2, pc_m);
      sub(8'h0c);
      exec(24'ha00c00, 2, 2, pc_m + 16'h1);
      a_m = x_m;
      exec(24'h9f0000, 1, 2, pc_m);
      $display("copy test done");
   endtask

   task automatic test_subtract();
      mem.ram[16'h0080] = 8'h0b;
      sub(8'h0b);
      exec(24'hb08000, 2, 3, 16'h0080);
      mem.ram[16'h1234] = 8'h10;
      sub(8'h10);
      exec(24'hc01234, 3, 4, 16'h1234);
      // two-byte offset already sets the high byte; adding the index gives no carry.
      mem.ram[16'h01fb] = 8'he0;
      sub(8'he0);
      exec(24'hd00100, 3, 5, 16'h01fb);
      mem.ram[16'h010b] = 8'h01;
      sub(8'h01);
      exec(24'he01000, 2, 4, 16'h010b);
      mem.ram[16'h00fb] = 8'h7f;
      sub(8'h7f);
      exec(24'hf00000, 1, 3, 16'h00fb);
      sub(8'h80);
      exec(24'ha08000, 2, 2, pc_m + 16'h1);
      $display("subtract test done");
   endtask

   task automatic test_memtest();
      sub(8'h01);
      exec(24'ha00100, 2, 2, pc_m + 16'h1);
      mem.ram[16'h0081] = 8'h00;
      nz(8'h00);
      exec(24'h3d8100, 2, 4, 16'h0081);
      nz(x_m);
      exec(24'h5d0000, 1, 3, pc_m);
      mem.ram[16'h0100] = 8'h00;
      nz(8'h00);
      exec(24'h6d0500, 2, 5, 16'h0100);
      nz(a_m);
      exec(24'h4d0000, 1, 3, pc_m);
      nz(8'h7f);
      exec(24'h7d0000, 1, 4, 16'h00fb);
      check(32'(mem.ram[16'h0081]), 32'h0);
      $display("memory test done");
   endtask

   task automatic test_trap();
      logic [31:0] d;
      logic [1:0] r;
      logic [15:0] p, last;
      int dt;
      p = pc_m;
      mem.ram[p] = 8'h83;
      mem.ram[VEC] = 8'h00;
      mem.ram[VEC + 16'h1] = 8'h60;
      for (int k = 0; k < 8; k++) mem.ram[16'h0060 + k] = 8'h9d;
      mem.ram[16'h0068] = 8'h8f;
      la.delete();
      lt.delete();
      axi_write(8'h00, 32'h3, r);
      d = 32'h0;
      // The mask rises one cycle after the last push, so poll on the mask.
      for (int k = 0; k < 20 && d[27] !== 1'b1; k++) axi_read(8'h08, d, r);
      check(32'(d[27]), 32'h1);
      check(32'(d[23:16]), 32'hfa);
      wait_halt();
      gap(p, 16'h0060, dt, last);
      check(32'(dt), 32'd10);
      check(32'(last), 32'(VEC + 16'h1));
      check({16'h0, mem.ram[16'h00fe], mem.ram[16'h00ff]},
         32'(p + 16'h1));
      check({8'h0, mem.ram[16'h00fd], mem.ram[16'h00fc], mem.ram[16'h00fb]},
         {8'h0, x_m, a_m, 5'b11100, n_m, z_m, c_m});
      axi_read(8'h04, d, r);
      check(d, 32'h3);
      axi_write(8'h04, 32'h2, r);
      axi_read(8'h04, d, r);
      check(d, 32'h1);
      axi_read(8'h0c, d, r);
      check(d, 32'h69);
      stk_m = 8'hfa;
      pc_m = 16'h0069;
      acc_check();
      $display("trap test done");
   endtask

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      test_regs();
      test_copy();
      test_subtract();
      test_memtest();
      test_trap();
      final_report();
   end
endmodule // testbench
